// ---- rtl/tmr_pkg.sv ----
package tmr_pkg;
    // APB byte addresses of the timer registers.
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] COUNT_ADDR = 8'h04;
    localparam logic [7:0] CMPA_ADDR = 8'h08;
    localparam logic [7:0] CMPB_ADDR = 8'h0C;
    localparam logic [7:0] FLAG_ADDR = 8'h10;
    localparam logic [7:0] MASK_ADDR = 8'h14;
    localparam logic [7:0] POWER_ADDR = 8'h18;
    localparam logic [7:0] SERVICE_ADDR = 8'h1C;
    // Control register fields.
    localparam int CTC_BIT = 3;
    localparam int CS_MSB = 2;
    // Flag and mask bit positions.
    localparam int OVF_BIT = 0;
    localparam int CMPA_BIT = 1;
    localparam int CMPB_BIT = 2;
    // Reset values and count limits.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [2:0] FLAG_RESET = 3'h0;
    localparam logic POWER_RESET = 1'b0;
    localparam logic [7:0] MAX_VALUE = 8'hFF;
    localparam logic [7:0] BOTTOM_VALUE = 8'h00;
    // Prescaler width: counts up to a divide by 1024.
    localparam int PRE_WIDTH = 10;
    localparam logic [9:0] PRE_RESET = 10'h000;
    // Clock source codes.
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
endpackage : tmr_pkg

// ---- rtl/tmr_edge_sync.sv ----
`timescale 1ns/1ps
module tmr_edge_sync (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Pin side.
    input wire logic pinIn,
    // Detected edges.
    output logic risePulse,
    output logic fallPulse
);
    logic meta;
    logic sync;
    logic last;

    // Two stages before any edge logic looks at the pin.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= pinIn;
            sync <= meta;
            last <= sync;
        end
    end

    assign risePulse = sync & ~last;
    assign fallPulse = ~sync & last;
endmodule : tmr_edge_sync

// ---- rtl/tmr_prescaler.sv ----
`timescale 1ns/1ps
module tmr_prescaler (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Control.
    input wire logic run,
    // Tap enables, one cycle each.
    output logic div8,
    output logic div64,
    output logic div256,
    output logic div1024
);
    logic [tmr_pkg::PRE_WIDTH-1:0] preCount;

    // Free counter; the taps fire while the low bits are all ones, in the cycle before they wrap to zero.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            preCount <= tmr_pkg::PRE_RESET;
        end else if (run) begin
            preCount <= preCount + 10'h001;
        end else begin
            preCount <= tmr_pkg::PRE_RESET;
        end
    end

    assign div8 = run && (preCount[2:0] == 3'h7);
    assign div64 = run && (preCount[5:0] == 6'h3F);
    assign div256 = run && (preCount[7:0] == 8'hFF);
    assign div1024 = run && (preCount[9:0] == 10'h3FF);
endmodule : tmr_prescaler

// ---- rtl/tmr_timer8.sv ----
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
module tmr_timer8 (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External count pin.
    input wire logic extCountPin,
    // Interrupt requests and their service acknowledges.
    input wire logic [2:0] irqAck,
    output logic [2:0] irqReq
);
    logic [3:0] timerControlReg;
    logic [7:0] countValueReg;
    logic [7:0] compareAValueReg;
    logic [7:0] compareBValueReg;
    logic [2:0] irqFlagReg;
    logic [2:0] irqMaskReg;
    logic timerPowerOffReg;
    logic blockMatchReg;
    logic [7:0] countValueNext;
    logic [2:0] clockSourceSelect;
    logic clearOnMatchSelect;
    logic timerTick;
    logic extRise;
    logic extFall;
    logic div8;
    logic div64;
    logic div256;
    logic div1024;
    logic accessPhase;
    logic writeStrobe;
    logic readStrobe;
    logic addrHit;
    logic countWrite;
    logic matchA;
    logic matchB;
    logic atTopA;
    logic [2:0] flagSet;
    logic [2:0] flagClear;
    logic [31:0] readValue;

    assign clockSourceSelect = timerControlReg[tmr_pkg::CS_MSB:0];
    assign clearOnMatchSelect = timerControlReg[tmr_pkg::CTC_BIT];

    // Bus decode: every transfer finishes in its first access cycle.
    assign accessPhase = psel && penable;
    assign writeStrobe = accessPhase && pwrite;
    assign readStrobe = accessPhase && !pwrite;
    assign addrHit = (paddr == tmr_pkg::CTRL_ADDR) || (paddr == tmr_pkg::COUNT_ADDR)
        || (paddr == tmr_pkg::CMPA_ADDR) || (paddr == tmr_pkg::CMPB_ADDR)
        || (paddr == tmr_pkg::FLAG_ADDR) || (paddr == tmr_pkg::MASK_ADDR)
        || (paddr == tmr_pkg::POWER_ADDR) || (paddr == tmr_pkg::SERVICE_ADDR);
    assign countWrite = writeStrobe && (paddr == tmr_pkg::COUNT_ADDR);

    // Prescaler only runs while powered, so a powered-off timer's prescaler does not toggle; the pin synchronizer still samples.
    tmr_prescaler uPrescaler (
        .mclk(mclk),
        .rst_n(rst_n),
        .run(!timerPowerOffReg),
        .div8(div8),
        .div64(div64),
        .div256(div256),
        .div1024(div1024)
    );

    // The pin is sampled regardless of how the port drives it.
    tmr_edge_sync uPinSync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinIn(extCountPin),
        .risePulse(extRise),
        .fallPulse(extFall)
    );

    // Tick select; the tick is an enable, never a clock.
    always_comb begin
        timerTick = 1'b0;
        unique case (clockSourceSelect)
            tmr_pkg::CS_STOP: timerTick = 1'b0;
            tmr_pkg::CS_DIV1: timerTick = 1'b1;
            tmr_pkg::CS_DIV8: timerTick = div8;
            tmr_pkg::CS_DIV64: timerTick = div64;
            tmr_pkg::CS_DIV256: timerTick = div256;
            tmr_pkg::CS_DIV1024: timerTick = div1024;
            tmr_pkg::CS_EXT_FALL: timerTick = extFall;
            tmr_pkg::CS_EXT_RISE: timerTick = extRise;
        endcase
        if (timerPowerOffReg) begin
            timerTick = 1'b0;
        end
    end

    // Comparators look at the count continuously; A also defines top in clear mode.
    assign matchA = (countValueReg == compareAValueReg);
    assign matchB = (countValueReg == compareBValueReg);
    assign atTopA = clearOnMatchSelect && matchA;

    // Next count: software write first, then clear on match, then increment.
    always_comb begin
        countValueNext = countValueReg;
        if (countWrite) begin
            countValueNext = pwdata[7:0];
        end else if (timerTick) begin
            if (atTopA) begin
                countValueNext = tmr_pkg::BOTTOM_VALUE;
            end else begin
                countValueNext = countValueReg + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            countValueReg <= tmr_pkg::COUNT_RESET;
        end else begin
            countValueReg <= countValueNext;
        end
    end

    // A count write arms a block that lasts until the next tick has passed.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            blockMatchReg <= 1'b0;
        end else if (countWrite) begin
            blockMatchReg <= 1'b1;
        end else if (timerTick) begin
            blockMatchReg <= 1'b0;
        end
    end

    // Hardware flag events; overflow is the 0xFF to 0x00 pass in either mode.
    always_comb begin
        flagSet = 3'h0;
        if (timerTick && !countWrite) begin
            // A clear-on-match from 0xFF to zero is still a pass through the maximum.
            flagSet[tmr_pkg::OVF_BIT] = (countValueReg == tmr_pkg::MAX_VALUE);
            flagSet[tmr_pkg::CMPA_BIT] = matchA && !blockMatchReg;
            flagSet[tmr_pkg::CMPB_BIT] = matchB && !blockMatchReg;
        end
        flagClear = irqAck;
        if (writeStrobe && (paddr == tmr_pkg::FLAG_ADDR)) begin
            flagClear = flagClear | pwdata[2:0];
        end
    end

    // Set wins over a clear in the same cycle so no event is lost.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : gFlag
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    irqFlagReg[gi] <= 1'b0;
                end else if (flagSet[gi]) begin
                    irqFlagReg[gi] <= 1'b1;
                end else if (flagClear[gi]) begin
                    irqFlagReg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Configuration registers written over the bus.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timerControlReg <= tmr_pkg::CTRL_RESET[3:0];
            compareAValueReg <= tmr_pkg::CMP_RESET;
            compareBValueReg <= tmr_pkg::CMP_RESET;
            irqMaskReg <= tmr_pkg::FLAG_RESET;
            timerPowerOffReg <= tmr_pkg::POWER_RESET;
        end else if (writeStrobe) begin
            unique case (paddr)
                tmr_pkg::CTRL_ADDR: timerControlReg <= pwdata[3:0];
                tmr_pkg::CMPA_ADDR: compareAValueReg <= pwdata[7:0];
                tmr_pkg::CMPB_ADDR: compareBValueReg <= pwdata[7:0];
                tmr_pkg::MASK_ADDR: irqMaskReg <= pwdata[2:0];
                tmr_pkg::POWER_ADDR: timerPowerOffReg <= pwdata[0];
                default: ;
            endcase
        end
    end

    // Read mux; reserved bits are zero.
    always_comb begin
        readValue = 32'h0000_0000;
        unique case (paddr)
            tmr_pkg::CTRL_ADDR: readValue[3:0] = timerControlReg;
            tmr_pkg::COUNT_ADDR: readValue[7:0] = countValueReg;
            tmr_pkg::CMPA_ADDR: readValue[7:0] = compareAValueReg;
            tmr_pkg::CMPB_ADDR: readValue[7:0] = compareBValueReg;
            tmr_pkg::FLAG_ADDR: readValue[2:0] = irqFlagReg;
            tmr_pkg::MASK_ADDR: readValue[2:0] = irqMaskReg;
            tmr_pkg::POWER_ADDR: readValue[0] = timerPowerOffReg;
            default: readValue = 32'h0000_0000;
        endcase
    end

    // Read data is registered in the setup cycle so the access phase sees it.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addrHit;
            if (psel && !penable && !pwrite) begin
                prdata <= readValue;
            end
        end
    end

    // Masked requests, registered so the port comes from a flop.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irqReq <= 3'h0;
        end else begin
            irqReq <= irqFlagReg & irqMaskReg;
        end
    end

    a_stop_holds: assert property (@(posedge mclk) disable iff (!rst_n)
        (clockSourceSelect == tmr_pkg::CS_STOP && !countWrite)
            |=> (countValueReg == $past(countValueReg)))
        else $error("Count moved while stopped.");

    a_write_wins: assert property (@(posedge mclk) disable iff (!rst_n)
        countWrite |=> (countValueReg == $past(pwdata[7:0])))
        else $error("Count write lost.");

    a_normal_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
        (timerTick && !countWrite && !clearOnMatchSelect)
            |=> (countValueReg == $past(countValueReg) + 8'h01))
        else $error("Normal mode did not increment.");

    a_ctc_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (timerTick && !countWrite && atTopA) |=> (countValueReg == 8'h00))
        else $error("Clear on match failed.");

    a_ovf_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (timerTick && !countWrite && countValueReg == 8'hFF)
            |=> (irqFlagReg[0] && countValueReg == 8'h00))
        else $error("Overflow flag not set on wrap.");

    a_match_block: assert property (@(posedge mclk) disable iff (!rst_n)
        (blockMatchReg && timerTick) |=> (!$rose(irqFlagReg[1]) && !$rose(irqFlagReg[2])))
        else $error("Match not blocked after count write.");

    a_cmpb_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (timerTick && !countWrite && matchB && !blockMatchReg) |=> irqFlagReg[2])
        else $error("Compare B flag not set.");

    a_power_off: assert property (@(posedge mclk) disable iff (!rst_n)
        timerPowerOffReg |-> !timerTick)
        else $error("Tick while powered off.");

    a_flag_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (irqAck[1] && !flagSet[1]) |=> !irqFlagReg[1])
        else $error("Service did not clear compare A flag.");

    a_irq_mask: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |=> (irqReq == ($past(irqFlagReg) & $past(irqMaskReg))))
        else $error("Interrupt request not gated by mask.");

    // Pin and bus read checks look at what enters the block; the software clear check uses its own writeStrobe decode.
    a_cmpa_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (timerTick && !countWrite && matchA && !blockMatchReg) |=> irqFlagReg[1])
        else $error("Compare A flag not set.");

    a_ovf_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        (irqFlagReg[0] && !flagClear[0]) |=> irqFlagReg[0])
        else $error("Overflow flag cleared by hardware.");

    a_sw_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (writeStrobe && paddr == tmr_pkg::FLAG_ADDR && pwdata[0] && !flagSet[0])
            |=> !irqFlagReg[0])
        else $error("Software write did not clear overflow flag.");

    a_ctrl_reserved: assert property (@(posedge mclk) disable iff (!rst_n)
        (psel && !penable && !pwrite && paddr == tmr_pkg::CTRL_ADDR)
            |=> (prdata[31:4] == 28'h0000000))
        else $error("Control reserved bits not zero.");

    a_flag_reserved: assert property (@(posedge mclk) disable iff (!rst_n)
        (psel && !penable && !pwrite && paddr == tmr_pkg::FLAG_ADDR)
            |=> (prdata[31:3] == 29'h00000000))
        else $error("Flag reserved bits not zero.");

    a_count_read: assert property (@(posedge mclk) disable iff (!rst_n)
        (psel && !penable && !pwrite && paddr == tmr_pkg::COUNT_ADDR)
            |=> (prdata[7:0] == $past(countValueReg)))
        else $error("Count read returned a stale value.");

    a_rise_tick: assert property (@(posedge mclk) disable iff (!rst_n)
        (clockSourceSelect == tmr_pkg::CS_EXT_RISE && timerTick)
            |-> ($past(extCountPin, 2) && !$past(extCountPin, 3)))
        else $error("Rise tick without a rising pin edge.");

    a_fall_tick: assert property (@(posedge mclk) disable iff (!rst_n)
        (clockSourceSelect == tmr_pkg::CS_EXT_FALL && timerTick)
            |-> (!$past(extCountPin, 2) && $past(extCountPin, 3)))
        else $error("Fall tick without a falling pin edge.");

    a_div1_tick: assert property (@(posedge mclk) disable iff (!rst_n)
        (clockSourceSelect == tmr_pkg::CS_DIV1 && !timerPowerOffReg) |-> timerTick)
        else $error("Undivided source missed a tick.");

    a_div8_gap: assert property (@(posedge mclk) disable iff (!rst_n)
        (clockSourceSelect == tmr_pkg::CS_DIV8 && timerTick)
            |=> (!timerTick || clockSourceSelect != tmr_pkg::CS_DIV8))
        else $error("Divide by 8 ticked twice in a row.");

    a_div64_gap: assert property (@(posedge mclk) disable iff (!rst_n)
        (clockSourceSelect == tmr_pkg::CS_DIV64 && timerTick)
            |=> (!timerTick || clockSourceSelect != tmr_pkg::CS_DIV64))
        else $error("Divide by 64 ticked twice in a row.");
endmodule : tmr_timer8

// ---- tb/tmr_timer8_tb.sv ----
`timescale 1ns/1ps
module tmr_timer8_tb;
    logic mclk;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic extCountPin;
    logic [2:0] irqAck;
    logic [2:0] irqReq;
    int numErrors;
    int checksDone;
    logic [31:0] q;
    logic e;

    tmr_timer8 uut (
        .mclk(mclk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .extCountPin(extCountPin),
        .irqAck(irqAck),
        .irqReq(irqReq)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic printVerdict;
        if (numErrors == 0 && checksDone > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : printVerdict

    task automatic checkWord(input string name, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            numErrors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : checkWord

    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] rq, output logic re);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            numErrors++;
            $display("MISMATCH pready expected 1 seen 0");
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rq;
        logic re;
        apb(1'b1, a, d, rq, re);
    endtask : wr

    task automatic rdChk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] rq;
        logic re;
        apb(1'b0, a, 8'h00, rq, re);
        checkWord(name, {24'h000000, exp}, rq);
    endtask : rdChk

    task automatic checkRange(input string name, input logic [31:0] lo, input logic [31:0] hi,
                              input logic [31:0] got);
        checksDone++;
        if ($isunknown(got) || got < lo || got > hi) begin
            numErrors++;
            $display("MISMATCH %s expected %h to %h seen %h", name, lo, hi, got);
        end
    endtask : checkRange

    task automatic rdRange(input string name, input logic [7:0] a, input logic [7:0] lo,
                           input logic [7:0] hi);
        logic [31:0] rq;
        logic re;
        apb(1'b0, a, 8'h00, rq, re);
        checkRange(name, {24'h000000, lo}, {24'h000000, hi}, rq);
    endtask : rdRange

    // Runs the timer for a span, then stops it so reads are stable.
    task automatic runFor(input logic [7:0] ctrl, input int cycles);
        wr(tmr_pkg::CTRL_ADDR, ctrl);
        repeat (cycles) @(posedge mclk);
        wr(tmr_pkg::CTRL_ADDR, 8'h00);
    endtask : runFor

    task automatic pulses(input int k);
        repeat (k) begin
            @(posedge mclk);
            extCountPin <= 1'b1;
            repeat (4) @(posedge mclk);
            extCountPin <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        repeat (6) @(posedge mclk);
    endtask : pulses

    initial begin
        repeat (20000) @(posedge mclk);
        numErrors++;
        printVerdict();
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        extCountPin = 1'b0;
        irqAck = 3'h0;
        numErrors = 0;
        checksDone = 0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        rdChk("ctrlReset", tmr_pkg::CTRL_ADDR, 8'h00);
        rdChk("countReset", tmr_pkg::COUNT_ADDR, 8'h00);
        rdChk("cmpAReset", tmr_pkg::CMPA_ADDR, 8'h00);
        rdChk("cmpBReset", tmr_pkg::CMPB_ADDR, 8'h00);
        rdChk("flagReset", tmr_pkg::FLAG_ADDR, 8'h00);
        rdChk("powerReset", tmr_pkg::POWER_ADDR, 8'h00);
        wr(tmr_pkg::CTRL_ADDR, 8'hFF);
        rdChk("ctrlReserved", tmr_pkg::CTRL_ADDR, 8'h0F);
        wr(tmr_pkg::CTRL_ADDR, 8'h00);
        wr(tmr_pkg::MASK_ADDR, 8'hFF);
        rdChk("maskReserved", tmr_pkg::MASK_ADDR, 8'h07);
        wr(tmr_pkg::MASK_ADDR, 8'h02);
        apb(1'b0, 8'h20, 8'h00, q, e);
        checkWord("unmappedData", 32'h00000000, q);
        checkWord("unmappedErr", 32'h00000001, {31'h00000000, e});
        // A stopped timer must keep a written count.
        wr(tmr_pkg::COUNT_ADDR, 8'h5A);
        repeat (20) @(posedge mclk);
        rdChk("countHold", tmr_pkg::COUNT_ADDR, 8'h5A);
        wr(tmr_pkg::CMPB_ADDR, 8'h10);
        wr(tmr_pkg::COUNT_ADDR, 8'h10);
        runFor(8'h01, 4);
        rdChk("blockedMatch", tmr_pkg::FLAG_ADDR, 8'h00);
        wr(tmr_pkg::CMPB_ADDR, 8'hF2);
        wr(tmr_pkg::COUNT_ADDR, 8'hF0);
        runFor(8'h01, 40);
        rdChk("normalWrap", tmr_pkg::FLAG_ADDR, 8'h07);
        wr(tmr_pkg::FLAG_ADDR, 8'h01);
        rdChk("swClear", tmr_pkg::FLAG_ADDR, 8'h06);
        repeat (2) @(posedge mclk);
        checkWord("irqMasked", 32'h00000002, {29'h00000000, irqReq});
        @(posedge mclk);
        irqAck <= 3'h2;
        @(posedge mclk);
        irqAck <= 3'h0;
        rdChk("ackClear", tmr_pkg::FLAG_ADDR, 8'h04);
        checkWord("irqAfterAck", 32'h00000000, {29'h00000000, irqReq});
        wr(tmr_pkg::FLAG_ADDR, 8'h07);
        wr(tmr_pkg::CMPA_ADDR, 8'h05);
        wr(tmr_pkg::COUNT_ADDR, 8'h00);
        runFor(8'h09, 50);
        rdChk("ctcFlags", tmr_pkg::FLAG_ADDR, 8'h02);
        rdRange("ctcBound", tmr_pkg::COUNT_ADDR, 8'h00, 8'h05);
        // Count above compare A runs through the wrap first.
        wr(tmr_pkg::FLAG_ADDR, 8'h07);
        wr(tmr_pkg::COUNT_ADDR, 8'h10);
        runFor(8'h09, 300);
        rdChk("ctcWrap", tmr_pkg::FLAG_ADDR, 8'h07);
        // With compare A at the maximum the clear from 0xFF is also an overflow.
        wr(tmr_pkg::FLAG_ADDR, 8'h07);
        wr(tmr_pkg::CMPA_ADDR, 8'hFF);
        wr(tmr_pkg::COUNT_ADDR, 8'hFD);
        runFor(8'h09, 4);
        rdChk("ctcTopMax", tmr_pkg::FLAG_ADDR, 8'h03);
        wr(tmr_pkg::CTRL_ADDR, 8'h07);
        wr(tmr_pkg::COUNT_ADDR, 8'h00);
        pulses(3);
        rdChk("pinRise", tmr_pkg::COUNT_ADDR, 8'h03);
        wr(tmr_pkg::CTRL_ADDR, 8'h06);
        wr(tmr_pkg::COUNT_ADDR, 8'h00);
        pulses(3);
        rdChk("pinFall", tmr_pkg::COUNT_ADDR, 8'h03);
        wr(tmr_pkg::CTRL_ADDR, 8'h00);
        wr(tmr_pkg::POWER_ADDR, 8'h01);
        wr(tmr_pkg::COUNT_ADDR, 8'h00);
        runFor(8'h01, 30);
        rdChk("powerOff", tmr_pkg::COUNT_ADDR, 8'h00);
        wr(tmr_pkg::POWER_ADDR, 8'h00);
        // 30 idle cycles plus the three bus cycles of the stopping write give 33 ticks.
        runFor(8'h01, 30);
        rdChk("powerOn", tmr_pkg::COUNT_ADDR, 8'h21);
        // Prescaler phase is free running, so each divided rate accepts either of two adjacent counts.
        wr(tmr_pkg::COUNT_ADDR, 8'h00);
        runFor(8'h02, 80);
        rdRange("div8", tmr_pkg::COUNT_ADDR, 8'h0A, 8'h0B);
        wr(tmr_pkg::COUNT_ADDR, 8'h00);
        runFor(8'h03, 200);
        rdRange("div64", tmr_pkg::COUNT_ADDR, 8'h03, 8'h04);
        wr(tmr_pkg::COUNT_ADDR, 8'h00);
        runFor(8'h04, 600);
        rdRange("div256", tmr_pkg::COUNT_ADDR, 8'h02, 8'h03);
        wr(tmr_pkg::COUNT_ADDR, 8'h00);
        runFor(8'h05, 2100);
        rdRange("div1024", tmr_pkg::COUNT_ADDR, 8'h02, 8'h03);
        printVerdict();
    end
endmodule : tmr_timer8_tb
